// ===== verilog/i2c_port_pkg.sv
package i2c_port_pkg;
  // ----------------------------------------------------------------
  // Bus addressing
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_UPPER = 6'h16;
  localparam int ADDR_W = 7;
  localparam int REG_NUM_W = 4;
  localparam logic [3:0] SUBADDR_UPPER = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int REF_CLK_HZ = 20000000;
  localparam int MAX_BIT_RATE_KBPS = 100;
  localparam int FILTER_LEN = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR_BYTE = 3'b011,
    ST_WR_ACK = 3'b100,
    ST_RD_BYTE = 3'b101,
    ST_RD_ACK = 3'b110
  } port_state_t;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } bus_event_t;

  typedef struct packed {
    logic [3:0] index;
    logic [7:0] data;
  } reg_access_t;
endpackage

// ===== verilog/i2c_slave_register_port.sv
// What this block does
// - Detect start: SDA falls while SCL high
// - SDA stable while SCL high, change when low
// - Own address acknowledged low on ninth pulse
// - Direction 0 master writes, 1 master reads
// - Eight data bits plus acknowledge, repeating freely
// - Detect stop: SDA rises while SCL high
// - After stop ignore all until matching address
// - Transmitter releases SDA during acknowledge bit
// - Accept many write bytes, acknowledge each one
// - Address 0101100 or 0101101 from select pin
// - First byte after start is address byte
// - Write: address, subaddress, data, all acknowledged
// - Subaddress upper four bits zero, low register
// - Read begins with subaddress write, stop optional
// - Read phase supplies data while master acknowledges
// - Read address acknowledged only when matching
// - Standard mode, up to 100 kbps
`timescale 1ns/10ps
`default_nettype none

module i2c_slave_register_port #(
  parameter int FILTER = i2c_port_pkg::FILTER_LEN
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_select,
  output logic [3:0] reg_index,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [7:0] reg_rdata,
  output logic busy
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Filter must stay well below a quarter of a 100 kbps bit at ref_clk
  localparam int MIN_HALF_BIT = i2c_port_pkg::REF_CLK_HZ / (i2c_port_pkg::MAX_BIT_RATE_KBPS * 1000) / 4;

  // The history shift needs at least two stages
  if (FILTER < 2 || FILTER > 8 || FILTER >= MIN_HALF_BIT) begin : g_filter_range
    $error("FILTER out of range");
  end

  // ----------------------------------------------------------------
  // Synchronise and filter
  // ----------------------------------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] sel_sync;
  logic [FILTER-1:0] scl_hist;
  logic [FILTER-1:0] sda_hist;
  logic scl_f;
  logic sda_f;
  logic scl_q;
  logic sda_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      sel_sync <= 2'h0;
      scl_hist <= '1;
      sda_hist <= '1;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      // Strap pin is asynchronous as well
      sel_sync <= {sel_sync[0], addr_select};
      scl_hist <= {scl_hist[FILTER-2:0], scl_sync[1]};
      sda_hist <= {sda_hist[FILTER-2:0], sda_sync[1]};
      // A level only moves once the whole history agrees: rejects glitches
      if (&scl_hist) begin
        scl_f <= 1'b1;
      end else if (~|scl_hist) begin
        scl_f <= 1'b0;
      end
      if (&sda_hist) begin
        sda_f <= 1'b1;
      end else if (~|sda_hist) begin
        sda_f <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  i2c_port_pkg::bus_event_t ev;
  assign ev.scl_rise = scl_f & ~scl_q;
  assign ev.scl_fall = ~scl_f & scl_q;
  assign ev.start = scl_f & scl_q & sda_q & ~sda_f;
  assign ev.stop = scl_f & scl_q & ~sda_q & sda_f;
  assign ev.sda = sda_f;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  i2c_port_pkg::port_state_t state;
  i2c_port_pkg::port_state_t next_state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic is_read;
  logic sub_pending;
  logic ack_drive;
  logic [7:0] tx_byte;

  wire [7:0] rx_byte = {shift[6:0], ev.sda};
  wire [6:0] own_addr = {i2c_port_pkg::ADDR_UPPER, sel_sync[1]};
  wire addr_hit = (rx_byte[7:1] == own_addr);
  wire sub_ok = (rx_byte[7:4] == i2c_port_pkg::SUBADDR_UPPER);
  wire byte_done = ev.scl_rise && (bit_cnt == i2c_port_pkg::BIT_LAST);
  wire ack_done = ev.scl_fall && (bit_cnt == i2c_port_pkg::BIT_ACK);

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      i2c_port_pkg::ST_IDLE: begin
        next_state = i2c_port_pkg::ST_IDLE;
      end
      i2c_port_pkg::ST_ADDR: begin
        if (byte_done) begin
          next_state = addr_hit ? i2c_port_pkg::ST_ADDR_ACK : i2c_port_pkg::ST_IDLE;
        end
      end
      i2c_port_pkg::ST_ADDR_ACK: begin
        if (ack_done) begin
          next_state = is_read ? i2c_port_pkg::ST_RD_BYTE : i2c_port_pkg::ST_WR_BYTE;
        end
      end
      i2c_port_pkg::ST_WR_BYTE: begin
        if (byte_done) begin
          next_state = i2c_port_pkg::ST_WR_ACK;
        end
      end
      i2c_port_pkg::ST_WR_ACK: begin
        if (ack_done) begin
          next_state = i2c_port_pkg::ST_WR_BYTE;
        end
      end
      i2c_port_pkg::ST_RD_BYTE: begin
        if (byte_done) begin
          next_state = i2c_port_pkg::ST_RD_ACK;
        end
      end
      i2c_port_pkg::ST_RD_ACK: begin
        // Not-acknowledge from the master ends the read
        if (ev.scl_rise) begin
          next_state = ev.sda ? i2c_port_pkg::ST_IDLE : i2c_port_pkg::ST_RD_ACK;
        end else if (ack_done) begin
          next_state = i2c_port_pkg::ST_RD_BYTE;
        end
      end
      default: begin
        next_state = i2c_port_pkg::ST_IDLE;
      end
    endcase
    // Start or stop override everything, even mid byte
    if (ev.start) begin
      next_state = i2c_port_pkg::ST_ADDR;
    end else if (ev.stop) begin
      next_state = i2c_port_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= i2c_port_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bit counter: 0..7 data, 8 acknowledge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bit_cnt <= 4'h0;
    end else if (ev.start) begin
      // The start's own SCL fall wraps this to 0, so it is not counted as a bit
      bit_cnt <= i2c_port_pkg::BIT_ACK;
    end else if (ev.scl_fall) begin
      bit_cnt <= (bit_cnt == i2c_port_pkg::BIT_ACK) ? 4'h0 : bit_cnt + 4'h1;
    end
  end

  // Sampling only on SCL rise relies on SDA being held while SCL is high
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      shift <= 8'h00;
    end else if (ev.scl_rise && bit_cnt < i2c_port_pkg::BIT_ACK) begin
      shift <= rx_byte;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      is_read <= 1'b0;
      sub_pending <= 1'b0;
    end else if (state == i2c_port_pkg::ST_ADDR && byte_done) begin
      is_read <= rx_byte[0];
      sub_pending <= ~rx_byte[0];
    end else if (state == i2c_port_pkg::ST_WR_BYTE && byte_done) begin
      sub_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register side
  // ----------------------------------------------------------------
  wire wr_byte_done = (state == i2c_port_pkg::ST_WR_BYTE) && byte_done;
  wire rd_load = (state == i2c_port_pkg::ST_ADDR_ACK && ack_done && is_read)
               || (state == i2c_port_pkg::ST_RD_ACK && ack_done);

  // Pointer survives a stop so a read can follow its subaddress phase
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_index <= 4'h0;
      reg_wdata <= 8'h00;
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      if (wr_byte_done && sub_pending) begin
        if (sub_ok) begin
          reg_index <= rx_byte[3:0];
        end
      end else if (wr_byte_done) begin
        reg_wdata <= rx_byte;
        reg_write <= 1'b1;
      end
      if (state == i2c_port_pkg::ST_WR_ACK && ack_done && !reg_write) begin
        reg_index <= reg_index;
      end
      if (reg_write) begin
        reg_index <= reg_index + 4'h1;
      end
      if (rd_load) begin
        tx_byte <= reg_rdata;
        reg_read <= 1'b1;
      end
      if (reg_read) begin
        reg_index <= reg_index + 4'h1;
      end
      if (state == i2c_port_pkg::ST_RD_BYTE && ev.scl_fall) begin
        tx_byte <= {tx_byte[6:0], 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // SDA drive
  // ----------------------------------------------------------------
  // Drive changes only after SCL falls, so it is stable across the high phase
  always_ff @(posedge ref_clk) begin
    if (srst || ev.stop || ev.start) begin
      ack_drive <= 1'b0;
    end else if (ev.scl_fall) begin
      ack_drive <= (next_state == i2c_port_pkg::ST_ADDR_ACK)
                || (next_state == i2c_port_pkg::ST_WR_ACK);
    end
  end

  // Read data bit comes from tx_byte MSB; acknowledge slot is released
  // Bit 0 is held into RD_ACK until its SCL fall, else SDA would rise with SCL high
  wire rd_slot = (state == i2c_port_pkg::ST_RD_BYTE || state == i2c_port_pkg::ST_RD_ACK)
               && bit_cnt < i2c_port_pkg::BIT_ACK;
  wire drive_low = ack_drive || (rd_slot && !tx_byte[7]);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sda_out <= 1'b1;
      sda_oe_n <= 1'b1;
      busy <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe_n <= ~drive_low;
      busy <= (state != i2c_port_pkg::ST_IDLE);
    end
  end

endmodule

`default_nettype wire

// ===== verif/i2c_slave_register_port_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_port_checker (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [3:0] reg_index,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic busy
);
  // ----------------
  // Port checks
  // ----------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_sda_stable; $changed(sda_oe_n) |-> !scl_in; endproperty
  a_sda_stable: assert property (p_sda_stable) else $error("sda moved, scl high");
  property p_out_low; !$past(srst) |-> !sda_out; endproperty
  a_out_low: assert property (p_out_low) else $error("sda drive level high");
  property p_idle_free; !busy |-> sda_oe_n; endproperty
  a_idle_free: assert property (p_idle_free) else $error("sda driven while idle");
  property p_wr_once; reg_write |=> !reg_write [*8]; endproperty
  a_wr_once: assert property (p_wr_once) else $error("write pulse too long");
  property p_rd_once; reg_read |=> !reg_read [*8]; endproperty
  a_rd_once: assert property (p_rd_once) else $error("read pulse too long");
  property p_wr_inc; reg_write |-> ##2 reg_index == $past(reg_index, 2) + 4'h1; endproperty
  a_wr_inc: assert property (p_wr_inc) else $error("no step after write");
  property p_rd_inc; reg_read |-> ##2 reg_index == $past(reg_index, 2) + 4'h1; endproperty
  a_rd_inc: assert property (p_rd_inc) else $error("no step after read");
  property p_wr_busy; reg_write |-> busy && !reg_read; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write outside transfer");
endmodule
bind i2c_slave_register_port i2c_port_checker mon (.ref_clk(ref_clk), .srst(srst), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .reg_index(reg_index), .reg_write(reg_write),
  .reg_read(reg_read), .busy(busy));
`default_nettype wire

// ===== verif/i2c_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model #(
  parameter int Q = 50
) (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl = 1'b1,
  output logic sda_low = 1'b0,
  output logic [7:0] rd_byte = 8'h00,
  output logic rd_stb = 1'b0
);
  // ----------------
  // Bus sequences
  // ----------------
  // Four steps of Q cycles a bit: 100 kbps, SDA moves mid low phase except in start and stop
  task automatic step(input logic c, input logic l);
    scl <= c;
    sda_low <= l;
    repeat (Q) @(posedge ref_clk);
  endtask
  task automatic start;
    step(scl, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask
  task automatic stop;
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  task automatic bit_io(input logic b, output logic r);
    step(1'b0, !b);
    step(1'b1, !b);
    r = sda;
    step(1'b1, !b);
    step(1'b0, !b);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx, output logic ao);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ai, ao);
  endtask
  task automatic rd(input logic ai);
    logic [7:0] v;
    logic a;
    xfer(8'hff, ai, v, a);
    rd_byte <= v;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verif/i2c_slave_register_port_test.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_register_port_test;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic addr_select = 1'b0;
  logic sda_oe_n, sda_out, reg_write, reg_read, busy, scl, sda_low, rd_stb, ack;
  logic [3:0] reg_index;
  logic [7:0] reg_wdata, rd_byte, rx;
  logic [7:0] reg_rdata = 8'h00;
  logic [7:0] mem [16];
  logic [7:0] d [4];
  logic [11:0] exp_q [$];
  int err_count = 0;
  int compares = 0;
  int seed = 13;
  // ----------------
  // Harness
  // ----------------
  // Open drain: either side pulls low, else the pull-up wins
  wire logic sda = !sda_low && (sda_oe_n || sda_out);
  i2c_slave_register_port dut (.ref_clk(ref_clk), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_select(addr_select), .reg_index(reg_index), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .busy(busy));
  i2c_master_model m (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low), .rd_byte(rd_byte),
    .rd_stb(rd_stb));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    reg_rdata <= mem[reg_index];
    if (reg_write === 1'b1) mem[reg_index] <= reg_wdata;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] want);
    compares++;
    if (got !== want) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  function automatic logic [11:0] nxt();
    return exp_q.size() > 0 ? exp_q.pop_front() : 12'hxxx;
  endfunction
  always @(posedge ref_clk) begin
    if (reg_write === 1'b1) chk({reg_index, reg_wdata}, nxt());
    if (rd_stb === 1'b1) chk({4'h0, rd_byte}, nxt());
  end
  task automatic wr(input logic [7:0] b, input logic want);
    m.xfer(b, 1'b1, rx, ack);
    chk({11'h000, ack}, {11'h000, want});
  endtask
  task automatic close_out;
    $display("compares=%0d errors=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    close_out();
  end
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 8'h00;
    for (int i = 0; i < 4; i++) d[i] = 8'($random(seed));
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (20) @(posedge ref_clk);
    m.start();
    wr(8'h58, 1'b0);
    chk({11'h000, busy}, 12'h001);
    wr(8'h0e, 1'b0);
    exp_q.push_back({4'he, d[0]});
    exp_q.push_back({4'hf, d[1]});
    exp_q.push_back({4'h0, d[2]});
    for (int i = 0; i < 3; i++) wr(d[i], 1'b0);
    m.stop();
    $display("write burst done");
    m.start();
    wr(8'h5a, 1'b1);
    wr(d[3], 1'b1);
    m.stop();
    $display("foreign address done");
    addr_select <= 1'b1;
    m.start();
    wr(8'h5a, 1'b0);
    wr(8'h13, 1'b0);
    exp_q.push_back({4'h1, d[3]});
    wr(d[3], 1'b0);
    m.stop();
    $display("select pin done");
    m.start();
    wr(8'h5a, 1'b0);
    wr(8'h0f, 1'b0);
    m.stop();
    m.start();
    wr(8'h5b, 1'b0);
    exp_q.push_back({4'h0, d[1]});
    exp_q.push_back({4'h0, d[2]});
    exp_q.push_back({4'h0, d[3]});
    m.rd(1'b0);
    m.rd(1'b0);
    m.rd(1'b1);
    m.stop();
    $display("split read done");
    m.start();
    wr(8'h5a, 1'b0);
    wr(8'h0e, 1'b0);
    m.start();
    wr(8'h5b, 1'b0);
    exp_q.push_back({4'h0, d[0]});
    m.rd(1'b1);
    m.stop();
    $display("repeated start read done");
    repeat (20) @(posedge ref_clk);
    chk({11'h000, busy}, 12'h000);
    chk(12'(exp_q.size()), 12'h000);
    close_out();
  end
endmodule
`default_nettype wire
